// File: gate_drive_fault_timing.sv
// Gate driver control timing: readiness, quick reset, faults, gates, serial port
// Summary of operation
// - After enable rises the device becomes ready within 10 ms, typically 5 ms.
// - Enable low pulse up to 10 us clears faults and resets gates, power stays.
// - An error event forces every gate output low, typically within 200 ns.
// - An error event asserts the active-low fault output, typically within 200 ns.
// - Dead time is inserted between gate turn-off and opposite turn-on, not added.
// - Dead time is selectable from 50 ns to 500 ns by the set pin.
// - After handshake the opposite gate turns on within 50 ns of dead time.
// - The driver can produce an on pulse as short as 50 ns.
// - Rising PWM turns off low gate, falling PWM turns off high gate.
// - Serial interface is slave only, never driving clock or chip select.
// - Serial output is high impedance while chip select is high.
// - Each new serial output bit launches after the serial clock rising edge.
`timescale 1ns/1ps
module gate_drive_fault_timing
  import gate_drive_pkg::*;
#(
  parameter int READY_CYCLES = READY_CYCLES_DFLT
) (
  // Clocks and reset
  input  wire logic                 mclk,
  input  wire logic                 sys_rst,
  input  wire logic                 sclk,
  // Controller inputs
  input  wire logic                 enGatePin,
  input  wire logic [PHASES-1:0]    pwmHighIn,
  input  wire logic [PHASES-1:0]    pwmLowIn,
  input  wire logic [DT_CODE_W-1:0] deadTimeSetPin,
  // Error event from protection sensing
  input  wire logic                 errorEventIn,
  // Serial port
  input  wire logic                 serialChipSelectN,
  input  wire logic                 serialDataIn,
  output logic                      serialDataOut,
  output logic                      serialDataOutOeN,
  // Gate and fault outputs
  output logic [PHASES-1:0]         highSideGateOut,
  output logic [PHASES-1:0]         lowSideGateOut,
  output logic                      faultIndicatorN
);
  localparam int FAULT_WIN = 2;

  logic [SYNC_W-1:0]    syncIn, syncOut;
  logic                 enS, errS, csS, csActS;
  logic [PHASES-1:0]    pwmHighS, pwmLowS;
  logic [DT_CODE_W-1:0] dtCodeS;
  logic [DT_CNT_W-1:0]  dtCycles;
  logic                 gatesEnable;

  pwr_t                 pwrState_ff, nxt_pwrState;
  logic [TIMER_W-1:0]   timer_ff, nxt_timer;
  logic [LOW_CNT_W-1:0] lowCnt_ff, nxt_lowCnt;
  logic                 enPrev_ff, csPrev_ff, nxt_enPrev, nxt_csPrev;
  logic                 fault_ff, nxt_fault, faultIndN_ff, nxt_faultIndN;
  logic                 oeN_ff, nxt_oeN;
  logic [SPI_WORD_W-1:0] cmdWord_ff, nxt_cmdWord;
  logic                 cmdNew_ff, nxt_cmdNew;
  logic                 quickReset, clrCmd;

  // Status frozen for the link while chip select is low
  logic [1:0]           statHold_ff, nxt_statHold;

  // Link-side state
  logic [SPI_CNT_W-1:0] bitIdx_ff;
  logic                 sdo_ff;
  logic [SPI_WORD_W-1:0] rxShift_ff;
  logic [SPI_WORD_W-1:0] txWord;
  logic                 linkRst;

  // Pin synchronisers; select goes in inverted so that reset reads as deselected
  assign syncIn = {enGatePin, pwmHighIn, pwmLowIn, errorEventIn, deadTimeSetPin,
                   !serialChipSelectN};
  sync3 #(.W(SYNC_W)) u_sync (
    .mclk     (mclk),
    .sys_rst  (sys_rst),
    .pinIn    (syncIn),
    .levelOut (syncOut)
  );
  assign {enS, pwmHighS, pwmLowS, errS, dtCodeS, csActS} = syncOut;
  assign csS = !csActS;

  // Dead-time cycles from the set pin code, rounded up
  assign dtCycles = DT_CNT_W'(((DT_MIN_NS + int'(dtCodeS) * DT_STEP_NS) * MCLK_MHZ
                               + NS_PER_US - 1) / NS_PER_US);

  // Enable edges and serial command decode
  assign quickReset = enS && !enPrev_ff && (pwrState_ff == PWR_READY);
  // Clear acts one cycle after frame end, on the word of the frame just ended
  assign clrCmd     = cmdNew_ff && cmdWord_ff[CMD_CLR_FAULT_BIT];

  // Power sequencing, fault latch and serial enable next values
  always_comb begin
    nxt_pwrState = pwrState_ff;
    nxt_timer    = timer_ff;
    nxt_lowCnt   = lowCnt_ff;
    nxt_enPrev   = enS;
    nxt_csPrev   = csS;
    nxt_cmdWord  = cmdWord_ff;
    nxt_cmdNew   = csS && !csPrev_ff;
    // Status follows the core only while deselected, so it is still during a frame
    nxt_statHold = csS ? {fault_ff, pwrState_ff == PWR_READY} : statHold_ff;
    unique case (pwrState_ff)
      PWR_OFF: begin
        if (enS) begin
          nxt_pwrState = PWR_WAKE;
          nxt_timer    = '0;
        end
      end
      PWR_WAKE: begin
        if (!enS) begin
          nxt_pwrState = PWR_OFF;
        end else if (timer_ff == TIMER_W'(READY_CYCLES - 1)) begin
          nxt_pwrState = PWR_READY;
        end else begin
          nxt_timer = timer_ff + 24'h000001;
        end
      end
      PWR_READY: begin
        // Low pulse past the quick limit powers everything down
        if (!enS && lowCnt_ff > LOW_CNT_W'(QUICK_CYCLES)) begin
          nxt_pwrState = PWR_OFF;
        end
      end
    endcase
    if (enS) begin
      nxt_lowCnt = '0;
    end else if (lowCnt_ff <= LOW_CNT_W'(QUICK_CYCLES)) begin
      nxt_lowCnt = lowCnt_ff + 9'h001;
    end
    // Frame end: chip select is high, the link shift register is stable
    if (csS && !csPrev_ff) begin
      nxt_cmdWord = rxShift_ff;
    end
    // A new error wins over any clear in the same cycle
    if (errS) begin
      nxt_fault = 1'b1;
    end else if (quickReset || clrCmd || pwrState_ff == PWR_OFF) begin
      nxt_fault = 1'b0;
    end else begin
      nxt_fault = fault_ff;
    end
    nxt_faultIndN = !nxt_fault;
    nxt_oeN       = csS;
  end

  // Register control state
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pwrState_ff  <= PWR_OFF;
      timer_ff     <= '0;
      lowCnt_ff    <= '0;
      enPrev_ff    <= 1'b0;
      csPrev_ff    <= 1'b1;
      cmdWord_ff   <= '0;
      cmdNew_ff    <= 1'b0;
      statHold_ff  <= '0;
      fault_ff     <= 1'b0;
      faultIndN_ff <= 1'b1;
      oeN_ff       <= 1'b1;
    end else begin
      pwrState_ff  <= nxt_pwrState;
      timer_ff     <= nxt_timer;
      lowCnt_ff    <= nxt_lowCnt;
      enPrev_ff    <= nxt_enPrev;
      csPrev_ff    <= nxt_csPrev;
      cmdWord_ff   <= nxt_cmdWord;
      cmdNew_ff    <= nxt_cmdNew;
      statHold_ff  <= nxt_statHold;
      fault_ff     <= nxt_fault;
      faultIndN_ff <= nxt_faultIndN;
      oeN_ff       <= nxt_oeN;
    end
  end

  // Gates follow the inputs only when ready, enabled and fault free
  assign gatesEnable = (pwrState_ff == PWR_READY) && enS && !fault_ff && !quickReset;

  // One half-bridge per phase
  for (genvar p = 0; p < PHASES; p++) begin : g_phase
    gate_phase u_phase (
      .mclk     (mclk),
      .sys_rst  (sys_rst),
      .enable   (gatesEnable),
      .reqHigh  (pwmHighS[p]),
      .reqLow   (pwmLowS[p]),
      .dtCycles (dtCycles),
      .gateHigh (highSideGateOut[p]),
      .gateLow  (lowSideGateOut[p])
    );
  end

  assign faultIndicatorN  = faultIndN_ff;
  assign serialDataOutOeN = oeN_ff;

  // Status word shifted out, fault first then ready.
  // The held status freezes a few system clocks after select falls, well before
  // the first serial clock edge, so the link reads a still word with no
  // synchroniser; the controller must leave that gap after lowering select.
  always_comb begin
    txWord = '0;
    txWord[STAT_FAULT_BIT] = statHold_ff[1];
    txWord[STAT_READY_BIT] = statHold_ff[0];
  end

  // Slave only: clock and select come from the controller; frame restarts on select high
  assign linkRst = sys_rst || serialChipSelectN;

  // Launch the next output bit on each serial clock rising edge
  always_ff @(posedge sclk or posedge linkRst) begin
    if (linkRst) begin
      bitIdx_ff <= SPI_FIRST_BIT;
      sdo_ff    <= 1'b0;
    end else begin
      sdo_ff    <= txWord[bitIdx_ff];
      bitIdx_ff <= bitIdx_ff - 4'h1;
    end
  end

  // Capture input bits on the falling edge, most significant first
  always_ff @(negedge sclk or posedge sys_rst) begin
    if (sys_rst) begin
      rxShift_ff <= '0;
    end else begin
      rxShift_ff <= {rxShift_ff[SPI_WORD_W-2:0], serialDataIn};
    end
  end

  assign serialDataOut = sdo_ff;

  a_ready_time: assert property (@(posedge mclk) disable iff (sys_rst)
    (pwrState_ff == PWR_WAKE && nxt_pwrState == PWR_READY)
      |-> timer_ff == TIMER_W'(READY_CYCLES - 1)) else $error("ready at wrong time");
  a_fault_gates_low: assert property (@(posedge mclk) disable iff (sys_rst)
    fault_ff |=> (highSideGateOut == '0 && lowSideGateOut == '0))
    else $error("gate on during fault");
  a_fault_pin: assert property (@(posedge mclk) disable iff (sys_rst)
    errS |-> ##[1:FAULT_WIN] !faultIndicatorN) else $error("fault output late");
  a_quick_clear: assert property (@(posedge mclk) disable iff (sys_rst)
    (quickReset && !errS) |=> (!fault_ff && pwrState_ff == PWR_READY))
    else $error("quick reset did not clear");
  a_sdo_release: assert property (@(posedge mclk) disable iff (sys_rst)
    csS |=> serialDataOutOeN) else $error("serial output driven while deselected");
  a_sdo_drive: assert property (@(posedge mclk) disable iff (sys_rst)
    !csS |=> !serialDataOutOeN) else $error("serial output not driven while selected");
  a_status_still: assert property (@(posedge mclk) disable iff (sys_rst)
    !csS |=> $stable(statHold_ff)) else $error("status moved during a frame");
  a_clear_cmd: assert property (@(posedge mclk) disable iff (sys_rst)
    (clrCmd && !errS) |=> !fault_ff) else $error("serial clear ignored");
  a_idle_gates: assert property (@(posedge mclk) disable iff (sys_rst)
    (pwrState_ff != PWR_READY) |=> (highSideGateOut == '0 && lowSideGateOut == '0))
    else $error("gate on before ready");
endmodule

// File: gate_drive_pkg.sv
// Shared constants and types for the gate driver control timing
package gate_drive_pkg;
  // Clock rate
  localparam int MCLK_MHZ       = 40;
  localparam int NS_PER_US      = 1000;
  // Start-up readiness after the gate enable rises
  localparam int READY_TYP_MS   = 5;
  localparam int READY_MAX_MS   = 10;
  localparam int READY_CYCLES_DFLT = READY_TYP_MS * MCLK_MHZ * 1000;
  localparam int TIMER_W        = 24;
  // Quick reset: longest enable low pulse (round down)
  localparam int QUICK_RESET_US = 10;
  localparam int QUICK_CYCLES   = QUICK_RESET_US * MCLK_MHZ;
  localparam int LOW_CNT_W      = 9;
  // Dead time range and code step
  localparam int DT_MIN_NS      = 50;
  localparam int DT_MAX_NS      = 500;
  localparam int DT_STEP_NS     = 30;
  localparam int DT_CODE_W      = 4;
  localparam int DT_CNT_W       = 5;
  localparam logic [DT_CNT_W-1:0] DT_CNT_MAX = 5'h1F;
  // Fault reaction
  localparam int FAULT_DELAY_NS = 200;
  localparam int FAULT_DELAY_CYCLES = FAULT_DELAY_NS * MCLK_MHZ / NS_PER_US;
  // Serial frame layout
  localparam int SPI_WORD_W     = 16;
  localparam int SPI_CNT_W      = 4;
  localparam logic [SPI_CNT_W-1:0] SPI_FIRST_BIT = 4'hF;
  localparam int STAT_FAULT_BIT = 15;
  localparam int STAT_READY_BIT = 14;
  localparam int CMD_CLR_FAULT_BIT = 0;
  // Phase count and synchroniser width
  localparam int PHASES         = 3;
  localparam int SYNC_W         = 1 + PHASES + PHASES + 1 + DT_CODE_W + 1;
  // Power state of the driver
  typedef enum logic [1:0] {PWR_OFF, PWR_WAKE, PWR_READY} pwr_t;
endpackage

// File: gate_phase.sv
// One half-bridge: turn-off ordering and dead-time insertion
`timescale 1ns/1ps
module gate_phase
  import gate_drive_pkg::*;
(
  // Clock and reset
  input  wire logic                mclk,
  input  wire logic                sys_rst,
  // Control
  input  wire logic                enable,
  input  wire logic                reqHigh,
  input  wire logic                reqLow,
  input  wire logic [DT_CNT_W-1:0] dtCycles,
  // Gate outputs
  output logic                     gateHigh,
  output logic                     gateLow
);
  logic                gateHigh_ff, gateLow_ff, nxt_gateHigh, nxt_gateLow;
  logic [DT_CNT_W-1:0] offCnt_ff, nxt_offCnt;
  logic                wantHigh, wantLow, gapDone;

  // Next gate levels: off at once, on only after the dead gap
  always_comb begin
    wantHigh = enable && reqHigh && !reqLow;
    wantLow  = enable && reqLow && !reqHigh;
    gapDone  = (offCnt_ff >= (dtCycles - 5'h01));
    nxt_gateHigh = wantHigh && (gateHigh_ff || (!gateLow_ff && gapDone));
    nxt_gateLow  = wantLow && (gateLow_ff || (!gateHigh_ff && gapDone));
    // Gap already provided by the controller counts toward the dead time
    if (gateHigh_ff || gateLow_ff) begin
      nxt_offCnt = '0;
    end else if (offCnt_ff != DT_CNT_MAX) begin
      nxt_offCnt = offCnt_ff + 5'h01;
    end else begin
      nxt_offCnt = offCnt_ff;
    end
  end

  // Register gate state
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      gateHigh_ff <= 1'b0;
      gateLow_ff  <= 1'b0;
      offCnt_ff   <= DT_CNT_MAX;
    end else begin
      gateHigh_ff <= nxt_gateHigh;
      gateLow_ff  <= nxt_gateLow;
      offCnt_ff   <= nxt_offCnt;
    end
  end

  assign gateHigh = gateHigh_ff;
  assign gateLow  = gateLow_ff;

  a_never_both: assert property (@(posedge mclk) disable iff (sys_rst)
    !(gateHigh_ff && gateLow_ff)) else $error("both gates on");
  a_min_dead_gap: assert property (@(posedge mclk) disable iff (sys_rst)
    $fell(gateLow_ff) |-> !gateHigh_ff [*2]) else $error("dead gap under 50 ns");
  a_turn_off: assert property (@(posedge mclk) disable iff (sys_rst)
    (!reqHigh || reqLow) |=> !gateHigh_ff) else $error("high gate not turned off");
  a_gap_turn_on: assert property (@(posedge mclk) disable iff (sys_rst)
    (wantHigh && !gateLow_ff && offCnt_ff >= dtCycles - 5'h01) |=> gateHigh_ff)
    else $error("high gate late after dead gap");
endmodule

// File: spi_controller_model.sv
// Controller model: drives chip select, serial clock and serial data in
`timescale 1ns/1ps
module spi_controller_model (
  // Serial pins toward the device
  output logic      sclk,
  output logic      serialChipSelectN,
  output logic      serialDataIn,
  // Resolved serial data out wire
  input  wire logic sdoWire
);
  localparam realtime HALF = 16.0;

  // Idle levels: clock stands still, chip select released
  initial begin
    sclk = 1'b0;
    serialChipSelectN = 1'b1;
    serialDataIn = 1'b0;
  end

  // One 16-bit frame, most significant bit first; the device only follows
  task automatic frame(input logic [15:0] tx, output logic [15:0] rx);
    serialChipSelectN = 1'b0;
    #200;
    for (int i = 15; i >= 0; i--) begin
      sclk = 1'b1;
      serialDataIn = tx[i];
      #HALF;
      rx[i] = sdoWire; // Bit launched at the rising edge is read here
      sclk = 1'b0;
      #HALF;
    end
    serialChipSelectN = 1'b1;
    serialDataIn = ~serialDataIn; // Released line stops showing the last bit
    #300;
  endtask
endmodule

// File: sync3.sv
// Three-stage pin synchroniser; a bit changes once stages two and three agree
`timescale 1ns/1ps
module sync3 #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         sys_rst,
  // Pins and synchronised levels
  input  wire logic [W-1:0] pinIn,
  output logic      [W-1:0] levelOut
);
  logic [W-1:0] stage1_ff, stage2_ff, stage3_ff, level_ff;
  logic [W-1:0] nxt_level;

  // Accept a bit only when the last two stages agree
  always_comb begin
    for (int i = 0; i < W; i++) begin
      nxt_level[i] = (stage2_ff[i] == stage3_ff[i]) ? stage3_ff[i] : level_ff[i];
    end
  end

  // Register the stages
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      stage1_ff <= '0;
      stage2_ff <= '0;
      stage3_ff <= '0;
      level_ff  <= '0;
    end else begin
      stage1_ff <= pinIn;
      stage2_ff <= stage1_ff;
      stage3_ff <= stage2_ff;
      level_ff  <= nxt_level;
    end
  end

  assign levelOut = level_ff;
endmodule

// File: tb_gate_drive_fault_timing.sv
// Testbench for the gate driver control timing block
`timescale 1ns/1ps
module tb_gate_drive_fault_timing;
  import gate_drive_pkg::*;
  localparam int RDY = 50;
  logic             mclk, sysRst, sclk, enGate, errEvent, csN, serial_data_in;
  logic [2:0]       pwmHigh, pwmLow, gateHigh, gateLow;
  logic [3:0]       dtCode;
  logic             serial_data_out, sdoOeN, faultN, sdoHeld;
  wire logic        sdoWire;
  int               badCount, compares;

  gate_drive_fault_timing #(.READY_CYCLES(RDY)) gate_drive_fault_timing_i (
    .mclk(mclk), .sys_rst(sysRst), .sclk(sclk), .enGatePin(enGate),
    .pwmHighIn(pwmHigh), .pwmLowIn(pwmLow), .deadTimeSetPin(dtCode),
    .errorEventIn(errEvent), .serialChipSelectN(csN), .serialDataIn(serial_data_in),
    .serialDataOut(serial_data_out), .serialDataOutOeN(sdoOeN), .highSideGateOut(gateHigh),
    .lowSideGateOut(gateLow), .faultIndicatorN(faultN));

  spi_controller_model spi_controller_model_i (
    .sclk(sclk), .serialChipSelectN(csN), .serialDataIn(serial_data_in), .sdoWire(sdoWire));

  // Released data wire shows the inverse of its last driven level
  always @* if (!sdoOeN) sdoHeld = serial_data_out;
  assign sdoWire = sdoOeN ? ~sdoHeld : serial_data_out;

  // System clock
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      badCount++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, badCount);
    if (badCount == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Enable rise: gates held low until ready, then follow the request
  task automatic startUp();
    enGate <= 1'b1;
    pwmHigh <= 3'h7;
    pwmLow <= 3'h0;
    cyc(RDY);
    check(16'(gateHigh), 16'h0000);
    cyc(25);
    check(16'(gateHigh), 16'h0007);
  endtask

  // Swap halves; time the turn-off and the dead gap on phase 0
  task automatic swap(input logic toLow, input int dt);
    int n;
    pwmHigh <= toLow ? 3'h0 : 3'h7;
    pwmLow <= toLow ? 3'h7 : 3'h0;
    n = 0;
    do begin @(posedge mclk); n++; end
    while ((toLow ? gateHigh[0] : gateLow[0]) !== 1'b0 && n < 10);
    check(16'(n <= 6), 16'h0001);
    n = 0;
    do begin @(posedge mclk); n++; end
    while ((toLow ? gateLow[0] : gateHigh[0]) !== 1'b1 && n < 30);
    check(16'(n), 16'(dt));
  endtask

  // Every dead-time code in both directions
  task automatic testDeadTime();
    int dt;
    for (int c = 0; c < 16; c++) begin
      dtCode <= 4'(c);
      dt = (50 + 30 * c + 24) / 25;
      swap(1'b1, dt);
      cyc(25);
      swap(1'b0, dt);
      cyc(25);
    end
  endtask

  // A two-cycle request gives a two-cycle on pulse
  task automatic testShortPulse();
    int n;
    dtCode <= 4'h0;
    pwmHigh <= 3'h0;
    cyc(30);
    pwmHigh <= 3'h7;
    cyc(2);
    pwmHigh <= 3'h0;
    n = 0;
    repeat (12) begin @(posedge mclk); n += int'(gateHigh[0] === 1'b1); end
    check(16'(n), 16'h0002);
  endtask

  // One frame with output-enable checks before, during and after
  task automatic xfer(input logic [15:0] tx, input logic [15:0] exp);
    logic [15:0] rx;
    check(16'(sdoOeN), 16'h0001);
    fork
      spi_controller_model_i.frame(tx, rx);
      begin #400; check(16'(sdoOeN), 16'h0000); end
    join
    check(rx, exp);
    check(16'(sdoOeN), 16'h0001);
  endtask

  // Error event, status read, serial clear, quick reset
  task automatic testFault();
    pwmHigh <= 3'h7;
    cyc(30);
    errEvent <= 1'b1;
    cyc(7);
    check(16'(faultN), 16'h0000);
    check(16'({gateHigh, gateLow}), 16'h0000);
    errEvent <= 1'b0;
    cyc(10);
    check(16'({gateHigh, faultN}), 16'h0000);
    xfer(16'h0000, 16'hC000);
    xfer(16'h0001, 16'hC000);
    cyc(30);
    check(16'({gateHigh, faultN}), 16'h000F);
    errEvent <= 1'b1;
    cyc(7);
    errEvent <= 1'b0;
    check(16'(faultN), 16'h0000);
    enGate <= 1'b0;
    cyc(20);
    enGate <= 1'b1;
    cyc(30);
    check(16'({gateHigh, faultN}), 16'h000F);
  endtask

  // Main sequence
  initial begin
    badCount = 0;
    compares = 0;
    sysRst = 1'b1;
    {enGate, errEvent, pwmHigh, pwmLow, dtCode} = '0;
    cyc(12);
    sysRst <= 1'b0;
    cyc(1);
    check(16'({gateHigh, gateLow, faultN, sdoOeN}), 16'h0003);
    startUp();
    testDeadTime();
    testShortPulse();
    testFault();
    enGate <= 1'b0;
    cyc(450); // Held beyond the quick limit for a full power-down
    startUp();
    conclude();
  end

  // Watchdog against a hang
  initial begin
    #500us;
    badCount++;
    conclude();
  end
endmodule
